//--- shared/smcd_params.svh
// Field positions, encodings and counts for the slave command decoder
`ifndef SMCD_PARAMS_SVH
`define SMCD_PARAMS_SVH
`define SMCD_CC_END        0
`define SMCD_CC_START      1
`define SMCD_CC_FUNC_LSB   2
`define SMCD_CC_SIZE_LSB   5
`define SMCD_FUNC_CSR      3'h0
`define SMCD_FUNC_EE       3'h1
`define SMCD_SIZE_BLOCK    2'h2
`define SMCD_CSR_OP        4
`define SMCD_CSR_RSVD      5
`define SMCD_CSR_REG_READ_UNCLAIMED      6
`define SMCD_CSR_REG_WRITE_UNCLAIMED      7
`define SMCD_EE_OP         0
`define SMCD_EE_USA        1
`define SMCD_EE_NAK        3
`define SMCD_EE_ARB        4
`define SMCD_EE_MIS        5
`define SMCD_CSR_NBYTES    4'h7
`define SMCD_EE_NBYTES     4'h5
`define SMCD_ADDR_HIGH_BYTE_BITS    6
`define SMCD_BUF_DEPTH     7
`endif

//--- shared/smcd_pkg.sv
// Types shared by the slave command decoder
package smcd_pkg;
   typedef struct packed {
      logic [2:0] func;
      logic [7:0] cmd;
      logic [7:0] b1;
      logic [7:0] b2;
      logic [7:0] b3;
      logic [7:0] b4;
      logic [7:0] b5;
      logic [7:0] b6;
   } smcd_req_s;
   typedef struct packed {
      logic [7:0]  cmd;
      logic [31:0] data;
      logic        rd;
   } smcd_rsp_s;
   typedef enum logic [1:0] {
      SMCD_IDLE = 2'b00,
      SMCD_CSR  = 2'b01,
      SMCD_EE   = 2'b10,
      SMCD_DONE = 2'b11
   } smcd_state_e;
endpackage

//--- rtl/smcd_cmd.sv
// Slave bus command decoder: register and EEPROM access with error status
`timescale 1ns/1ps
//----------------------------------------------------------------------
// What this block does
// - Register transfer: code, count, cmd, addr, four data
// - Function field: 0 register, 1 EEPROM, else reserved
// - Refuse command while busy or data unavailable
// - Command bits 3:0 enable data byte lanes
// - Register command bit 4: 0 write, 1 read
// - Bit 6 flags unclaimed register read, clear-on-read
// - Bit 7 flags unclaimed register write, clear-on-read
// - Clear error bits only mean access was claimed
// - EEPROM transfer: code, count, cmd, dev, addr, data
// - Count byte only in block transfers, includes status
// - EEPROM bit 1 picks given or configured address
// - EEPROM address is low byte then high byte
// - EEPROM command bit 0: 0 write, 1 read
// - Bit 3 flags unexpected nack, clear-on-read
// - Bit 4 flags sixteen lost arbitrations, clear-on-read
// - Bit 5 flags misplaced start/stop, clear-on-read
// - EEPROM error bits mirror master status events
//----------------------------------------------------------------------
`include "smcd_params.svh"
module smcd_cmd
   import smcd_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic        lnk_clk,
   input  wire logic        rx_start,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_byte,
   input  wire logic        rx_stop,
   output logic             rx_nack,
   input  wire logic        tx_start,
   input  wire logic        tx_req,
   output logic             tx_nack,
   output logic [7:0]       tx_byte,
   output logic             csr_req,
   output logic             csr_write,
   output logic [13:0]      csr_addr,
   output logic [3:0]       csr_be,
   output logic [31:0]      csr_wdata,
   input  wire logic        csr_ack,
   input  wire logic        csr_claimed,
   input  wire logic [31:0] csr_rdata,
   input  wire logic [6:0]  master_eeprom_addr_field,
   output logic             ee_req,
   output logic             ee_write,
   output logic [6:0]       ee_dev_addr,
   output logic [15:0]      ee_addr,
   output logic [7:0]       ee_wdata,
   input  wire logic        ee_done,
   input  wire logic [7:0]  ee_rdata,
   input  wire logic        unexpected_nack_flag,
   input  wire logic        arbitration_lost_flag,
   input  wire logic        misplaced_cond_flag
);
   //-------------------------------------------------------------------
   // Reset release in both domains
   //-------------------------------------------------------------------
   logic [1:0] srst_reg;
   logic [1:0] lrst_reg;
   logic       srst_b;
   logic       lrst_b;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) srst_reg <= 2'h0;
      else        srst_reg <= {srst_reg[0], 1'b1};
   end
   always_ff @(posedge lnk_clk or negedge rst_b) begin
      if (!rst_b) lrst_reg <= 2'h0;
      else        lrst_reg <= {lrst_reg[0], 1'b1};
   end
   assign srst_b = srst_reg[1];
   assign lrst_b = lrst_reg[1];

   //-------------------------------------------------------------------
   // Link side: byte parsing
   //-------------------------------------------------------------------
   logic [7:0]  cc_reg;
   logic [7:0]  count_byte_reg;
   logic [3:0]  pos_reg;
   logic [7:0]  buf_reg [0:`SMCD_BUF_DEPTH-1];
   logic        busy_reg;
   logic        rsp_ok_reg;
   logic        req_tgl_reg;
   smcd_req_s   req_reg;
   logic [2:0]  done_sync_reg;
   logic        done_tgl_reg;
   logic [3:0]  tx_idx_reg;
   logic [7:0]  tx_byte_reg;
   logic        block;
   logic [3:0]  hdr;
   logic [2:0]  cc_func;
   logic        done_seen;
   smcd_rsp_s   rsp_reg;

   assign block   = cc_reg[`SMCD_CC_SIZE_LSB +: 2] == `SMCD_SIZE_BLOCK;
   assign hdr     = block ? 4'h2 : 4'h1;
   assign cc_func = cc_reg[`SMCD_CC_FUNC_LSB +: 3];
   assign done_seen = done_sync_reg[2] != done_sync_reg[1];
   assign rx_nack = rx_valid & busy_reg;
   assign tx_nack = tx_req & (busy_reg | ~rsp_ok_reg);

   function automatic logic [3:0] nbytes(input logic [2:0] f);
      nbytes = (f == `SMCD_FUNC_EE) ? `SMCD_EE_NBYTES : `SMCD_CSR_NBYTES;
   endfunction

   // Command code, count and fields land in order of arrival
   always_ff @(posedge lnk_clk or negedge lrst_b) begin
      if (!lrst_b) begin
         cc_reg         <= 8'h00;
         count_byte_reg <= 8'h00;
         pos_reg        <= 4'h0;
      end else if (rx_start) begin
         pos_reg <= 4'h0;
      end else if (rx_valid && !busy_reg) begin
         if (pos_reg == 4'h0) cc_reg <= rx_byte;
         else if (pos_reg == 4'h1 && block) count_byte_reg <= rx_byte;
         if (pos_reg != 4'hf) pos_reg <= pos_reg + 4'h1;
      end
   end

   // Field buffer: written by the host, overlaid by the answer
   always_ff @(posedge lnk_clk or negedge lrst_b) begin
      if (!lrst_b) begin
         for (int i = 0; i < `SMCD_BUF_DEPTH; i++) buf_reg[i] <= 8'h00;
      end else if (done_seen) begin
         buf_reg[0] <= rsp_reg.cmd;
         if (rsp_reg.rd && cc_func == `SMCD_FUNC_EE) begin
            buf_reg[4] <= rsp_reg.data[7:0];
         end else if (rsp_reg.rd) begin
            for (int i = 0; i < 4; i++)
               if (buf_reg[0][i]) buf_reg[3+i] <= rsp_reg.data[8*i +: 8];
         end
      end else if (rx_valid && !busy_reg && pos_reg >= hdr &&
                   pos_reg - hdr < 4'(`SMCD_BUF_DEPTH)) begin
         buf_reg[3'(pos_reg - hdr)] <= rx_byte;
      end
   end

   // Stop with end-of-sequence hands the command to the core side
   always_ff @(posedge lnk_clk or negedge lrst_b) begin
      if (!lrst_b) begin
         busy_reg    <= 1'b0;
         rsp_ok_reg  <= 1'b0;
         req_tgl_reg <= 1'b0;
         req_reg     <= '0;
      end else if (done_seen) begin
         busy_reg   <= 1'b0;
         rsp_ok_reg <= 1'b1;
      end else if (rx_stop && !busy_reg && pos_reg > hdr && cc_reg[`SMCD_CC_END] &&
                   (cc_func == `SMCD_FUNC_CSR || cc_func == `SMCD_FUNC_EE)) begin
         busy_reg    <= 1'b1;
         rsp_ok_reg  <= 1'b0;
         req_tgl_reg <= ~req_tgl_reg;
         req_reg     <= '{cc_func, buf_reg[0], buf_reg[1], buf_reg[2], buf_reg[3],
                          buf_reg[4], buf_reg[5], buf_reg[6]};
      end
   end

   always_ff @(posedge lnk_clk or negedge lrst_b) begin
      if (!lrst_b) done_sync_reg <= 3'h0;
      else         done_sync_reg <= {done_sync_reg[1:0], done_tgl_reg};
   end

   // Read-back stream: count (block only), then the fields
   always_ff @(posedge lnk_clk or negedge lrst_b) begin
      if (!lrst_b) begin
         tx_idx_reg  <= 4'h0;
         tx_byte_reg <= 8'h00;
      end else if (tx_start) begin
         tx_idx_reg <= 4'h0;
      end else if (tx_req && !tx_nack) begin
         if (block && tx_idx_reg == 4'h0) tx_byte_reg <= {4'h0, nbytes(cc_func)};
         else tx_byte_reg <= buf_reg[3'(tx_idx_reg - (block ? 4'h1 : 4'h0))];
         if (tx_idx_reg < nbytes(cc_func)) tx_idx_reg <= tx_idx_reg + 4'h1;
      end
   end
   assign tx_byte = tx_byte_reg;

   //-------------------------------------------------------------------
   // Core side: command execution and error flags
   //-------------------------------------------------------------------
   logic [2:0]  req_sync_reg;
   logic        req_seen;
   smcd_state_e state_reg;
   logic        reg_read_unclaimed_reg;
   logic        reg_write_unclaimed_reg;
   logic        nak_reg;
   logic        arb_reg;
   logic        mis_reg;
   logic [31:0] rdata_reg;
   logic        is_rd;

   assign req_seen = req_sync_reg[2] != req_sync_reg[1];
   assign is_rd = (req_reg.func == `SMCD_FUNC_EE) ? req_reg.cmd[`SMCD_EE_OP] :
                                                    req_reg.cmd[`SMCD_CSR_OP];

   always_ff @(posedge sys_clk or negedge srst_b) begin
      if (!srst_b) req_sync_reg <= 3'h0;
      else         req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
   end

   always_ff @(posedge sys_clk or negedge srst_b) begin
      if (!srst_b) begin
         state_reg <= SMCD_IDLE;
         csr_req   <= 1'b0;
         ee_req    <= 1'b0;
         rdata_reg <= 32'h0;
      end else begin
         csr_req <= 1'b0;
         ee_req  <= 1'b0;
         case (state_reg)
            SMCD_IDLE: begin
               if (req_seen && req_reg.func == `SMCD_FUNC_EE) begin
                  ee_req    <= 1'b1;
                  state_reg <= SMCD_EE;
               end else if (req_seen) begin
                  csr_req   <= 1'b1;
                  state_reg <= SMCD_CSR;
               end
            end
            SMCD_CSR: begin
               if (csr_ack) begin
                  rdata_reg <= csr_rdata;
                  state_reg <= SMCD_DONE;
               end
            end
            SMCD_EE: begin
               if (ee_done) begin
                  rdata_reg <= {24'h0, ee_rdata};
                  state_reg <= SMCD_DONE;
               end
            end
            SMCD_DONE: state_reg <= SMCD_IDLE;
            default:   state_reg <= SMCD_IDLE;
         endcase
      end
   end

   // Request fields are stable while the link side is busy
   always_ff @(posedge sys_clk or negedge srst_b) begin
      if (!srst_b) begin
         csr_write   <= 1'b0;
         csr_addr    <= 14'h0;
         csr_be      <= 4'h0;
         csr_wdata   <= 32'h0;
         ee_write    <= 1'b0;
         ee_dev_addr <= 7'h0;
         ee_addr     <= 16'h0;
         ee_wdata    <= 8'h00;
      end else if (req_seen) begin
         csr_write   <= ~req_reg.cmd[`SMCD_CSR_OP];
         csr_addr    <= {req_reg.b2[`SMCD_ADDR_HIGH_BYTE_BITS-1:0], req_reg.b1};
         csr_be      <= req_reg.cmd[3:0];
         csr_wdata   <= {req_reg.b6, req_reg.b5, req_reg.b4, req_reg.b3};
         ee_write    <= ~req_reg.cmd[`SMCD_EE_OP];
         ee_dev_addr <= req_reg.cmd[`SMCD_EE_USA] ? req_reg.b1[7:1]
                                                  : master_eeprom_addr_field;
         ee_addr     <= {req_reg.b3, req_reg.b2};
         ee_wdata    <= req_reg.b4;
      end
   end

   // Sticky error flags; a new event wins over the clear on return
   always_ff @(posedge sys_clk or negedge srst_b) begin
      if (!srst_b) begin
         reg_read_unclaimed_reg <= 1'b0;
         reg_write_unclaimed_reg <= 1'b0;
         nak_reg  <= 1'b0;
         arb_reg  <= 1'b0;
         mis_reg  <= 1'b0;
      end else begin
         if (state_reg == SMCD_CSR && csr_ack && !csr_write)
            reg_read_unclaimed_reg <= ~csr_claimed;
         else if (state_reg == SMCD_DONE && req_reg.func == `SMCD_FUNC_CSR)
            reg_read_unclaimed_reg <= 1'b0;
         if (state_reg == SMCD_CSR && csr_ack && csr_write)
            reg_write_unclaimed_reg <= ~csr_claimed;
         else if (state_reg == SMCD_DONE && req_reg.func == `SMCD_FUNC_CSR)
            reg_write_unclaimed_reg <= 1'b0;
         if (unexpected_nack_flag) nak_reg <= 1'b1;
         else if (state_reg == SMCD_DONE && req_reg.func == `SMCD_FUNC_EE) nak_reg <= 1'b0;
         if (arbitration_lost_flag) arb_reg <= 1'b1;
         else if (state_reg == SMCD_DONE && req_reg.func == `SMCD_FUNC_EE) arb_reg <= 1'b0;
         if (misplaced_cond_flag) mis_reg <= 1'b1;
         else if (state_reg == SMCD_DONE && req_reg.func == `SMCD_FUNC_EE) mis_reg <= 1'b0;
      end
   end

   // Answer holds until the next request; reserved bits return zero
   always_ff @(posedge sys_clk or negedge srst_b) begin
      if (!srst_b) begin
         rsp_reg      <= '0;
         done_tgl_reg <= 1'b0;
      end else if (state_reg == SMCD_DONE) begin
         done_tgl_reg <= ~done_tgl_reg;
         rsp_reg.rd   <= is_rd;
         rsp_reg.data <= rdata_reg;
         if (req_reg.func == `SMCD_FUNC_EE)
            rsp_reg.cmd <= {2'b00, mis_reg, arb_reg, nak_reg, 1'b0, req_reg.cmd[1:0]};
         else
            rsp_reg.cmd <= {reg_write_unclaimed_reg, reg_read_unclaimed_reg, 1'b0, req_reg.cmd[4:0]};
      end
   end

   //-------------------------------------------------------------------
   // Assertions
   //-------------------------------------------------------------------
   property p_nack_busy;
      @(posedge lnk_clk) disable iff (!lrst_b) rx_valid && busy_reg |-> rx_nack && $stable(cc_reg);
   endproperty
   a_nack_busy: assert property (p_nack_busy) else $error("byte taken while busy");
   property p_lanes;
      @(posedge sys_clk) disable iff (!srst_b) csr_req |-> csr_be == req_reg.cmd[3:0];
   endproperty
   a_lanes: assert property (p_lanes) else $error("byte enables wrong");
   property p_csr_op;
      @(posedge sys_clk) disable iff (!srst_b)
         csr_req |-> csr_write == !req_reg.cmd[`SMCD_CSR_OP] && state_reg == SMCD_CSR;
   endproperty
   a_csr_op: assert property (p_csr_op) else $error("register direction wrong");
   property p_reg_read_unclaimed;
      @(posedge sys_clk) disable iff (!srst_b)
         state_reg == SMCD_CSR && csr_ack && !csr_write && !csr_claimed |=> reg_read_unclaimed_reg ##1 rsp_reg.cmd[6];
   endproperty
   a_reg_read_unclaimed: assert property (p_reg_read_unclaimed) else $error("read error not reported");
   property p_reg_write_unclaimed;
      @(posedge sys_clk) disable iff (!srst_b)
         state_reg == SMCD_CSR && csr_ack && csr_write && !csr_claimed |=> reg_write_unclaimed_reg ##1 rsp_reg.cmd[7];
   endproperty
   a_reg_write_unclaimed: assert property (p_reg_write_unclaimed) else $error("write error not reported");
   property p_ee_dev;
      @(posedge sys_clk) disable iff (!srst_b) ee_req |-> ee_dev_addr ==
         (req_reg.cmd[`SMCD_EE_USA] ? req_reg.b1[7:1] : $past(master_eeprom_addr_field));
   endproperty
   a_ee_dev: assert property (p_ee_dev) else $error("device address wrong");
   property p_ee_addr;
      @(posedge sys_clk) disable iff (!srst_b)
         ee_req |-> ee_addr == {req_reg.b3, req_reg.b2} && ee_write == !req_reg.cmd[0];
   endproperty
   a_ee_addr: assert property (p_ee_addr) else $error("eeprom address or op wrong");
   property p_func;
      @(posedge sys_clk) disable iff (!srst_b)
         state_reg == SMCD_IDLE && req_seen && req_reg.func == `SMCD_FUNC_EE |=> ee_req && !csr_req;
   endproperty
   a_func: assert property (p_func) else $error("function not honoured");
   property p_nak;
      @(posedge sys_clk) disable iff (!srst_b) unexpected_nack_flag |=> nak_reg;
   endproperty
   a_nak: assert property (p_nak) else $error("nack event lost");
   property p_clear;
      @(posedge sys_clk) disable iff (!srst_b) state_reg == SMCD_DONE &&
         req_reg.func == `SMCD_FUNC_EE && !arbitration_lost_flag |=> !arb_reg ##[1:8] 1'b1;
   endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared on return");
   c_csr_rd: cover property (@(posedge sys_clk) disable iff (!srst_b) csr_req && !csr_write);
   c_csr_wr: cover property (@(posedge sys_clk) disable iff (!srst_b) csr_req && csr_write);
   c_ee:     cover property (@(posedge sys_clk) disable iff (!srst_b) ee_req);
   c_nack:   cover property (@(posedge lnk_clk) disable iff (!lrst_b) rx_nack);
endmodule // smcd_cmd

//--- verif/smcd_host.sv
// Host model of the link side: sends frames, probes refusal, reads answers
`timescale 1ns/1ps
module smcd_host (
   input  wire logic       lnk_clk,
   output logic            rx_start,
   output logic            rx_valid,
   output logic [7:0]      rx_byte,
   output logic            rx_stop,
   output logic            tx_start,
   output logic            tx_req,
   input  wire logic       rx_nack,
   input  wire logic       tx_nack,
   input  wire logic [7:0] tx_byte
);
   logic [7:0] frame [9];
   logic       nk0;
   initial begin
      rx_start = 1'b0;
      rx_valid = 1'b0;
      rx_byte  = 8'h00;
      rx_stop  = 1'b0;
      tx_start = 1'b0;
      tx_req   = 1'b0;
   end
   // Start, n bytes back to back, stop, then a short idle gap
   task automatic send(input int n);
      @(posedge lnk_clk);
      rx_start <= 1'b1;
      @(posedge lnk_clk);
      rx_start <= 1'b0;
      for (int i = 0; i < n; i++) begin
         rx_valid <= 1'b1;
         rx_byte  <= frame[i];
         @(posedge lnk_clk);
      end
      rx_valid <= 1'b0;
      rx_byte  <= ~frame[n-1];
      rx_stop  <= 1'b1;
      @(posedge lnk_clk);
      rx_stop  <= 1'b0;
      repeat (3) @(posedge lnk_clk);
   endtask
   task automatic poke(output logic nk);
      rx_valid <= 1'b1;
      @(negedge lnk_clk);
      nk = rx_nack;
      @(posedge lnk_clk);
      rx_valid <= 1'b0;
      @(posedge lnk_clk);
   endtask
   task automatic rd_start();
      tx_start <= 1'b1;
      @(posedge lnk_clk);
      tx_start <= 1'b0;
      @(posedge lnk_clk);
   endtask
   // Retries a refused request, as a host does on a not-acknowledge
   task automatic get(output logic [7:0] b);
      logic nk;
      nk = 1'b1;
      for (int i = 0; i < 500 && nk; i++) begin
         tx_req <= 1'b1;
         @(negedge lnk_clk);
         nk = tx_nack;
         if (i == 0) nk0 = nk;
         @(posedge lnk_clk);
         tx_req <= 1'b0;
         @(posedge lnk_clk);
      end
      b = tx_byte;
   endtask
endmodule // smcd_host

//--- verif/smcd_cmd_tb.sv
// Self-checking bench for the slave command decoder
`timescale 1ns/1ps
module smcd_cmd_tb;
   logic        sys_clk = 1'b0;
   logic        lnk_clk = 1'b0;
   logic        rst_b   = 1'b0;
   logic        rx_start, rx_valid, rx_stop, rx_nack, tx_start, tx_req, tx_nack;
   logic        csr_req, csr_write, ee_req, ee_write, nk;
   logic        csr_ack = 1'b0, csr_claimed = 1'b0, ee_done = 1'b0, clm = 1'b1;
   logic [7:0]  rx_byte, tx_byte, ee_wdata, ee_val, ee_rdata = 8'h00;
   logic [13:0] csr_addr;
   logic [3:0]  csr_be;
   logic [31:0] csr_wdata, rd_val, csr_rdata = 32'h0;
   logic [6:0]  ee_dev_addr, cfg_addr = 7'h00;
   logic [15:0] ee_addr;
   logic [2:0]  flg = 3'h0;
   logic [50:0] cap_csr;
   logic [31:0] cap_ee;
   logic [7:0]  bad [3] = '{8'h4b, 8'h42, 8'h5f};
   int          dly = 1, n_req = 0, n_errors = 0, checks = 0, k;

   always #12.5 sys_clk = ~sys_clk;
   initial begin
      #1.3;
      forever #3 lnk_clk = ~lnk_clk;
   end

   smcd_host u_host (.lnk_clk(lnk_clk), .rx_start(rx_start), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .rx_stop(rx_stop), .tx_start(tx_start), .tx_req(tx_req),
      .rx_nack(rx_nack), .tx_nack(tx_nack), .tx_byte(tx_byte));

   smcd_cmd u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .lnk_clk(lnk_clk),
      .rx_start(rx_start), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_stop(rx_stop),
      .rx_nack(rx_nack), .tx_start(tx_start), .tx_req(tx_req), .tx_nack(tx_nack),
      .tx_byte(tx_byte), .csr_req(csr_req), .csr_write(csr_write), .csr_addr(csr_addr),
      .csr_be(csr_be), .csr_wdata(csr_wdata), .csr_ack(csr_ack),
      .csr_claimed(csr_claimed), .csr_rdata(csr_rdata),
      .master_eeprom_addr_field(cfg_addr), .ee_req(ee_req), .ee_write(ee_write),
      .ee_dev_addr(ee_dev_addr), .ee_addr(ee_addr), .ee_wdata(ee_wdata),
      .ee_done(ee_done), .ee_rdata(ee_rdata), .unexpected_nack_flag(flg[0]),
      .arbitration_lost_flag(flg[1]), .misplaced_cond_flag(flg[2]));

   //------------------------------------------------------------------
   // Core-side targets: capture the request, answer after dly cycles
   //------------------------------------------------------------------
   always begin
      @(negedge sys_clk);
      if (csr_req === 1'b1) begin
         n_req++;
         cap_csr = {csr_write, csr_addr, csr_be, csr_wdata};
         repeat (dly) @(posedge sys_clk);
         csr_ack     <= 1'b1;
         csr_claimed <= clm;
         csr_rdata   <= rd_val;
         @(posedge sys_clk);
         csr_ack     <= 1'b0;
         csr_rdata   <= ~rd_val;
      end
   end
   always begin
      @(negedge sys_clk);
      if (ee_req === 1'b1) begin
         n_req++;
         cap_ee = {ee_write, ee_dev_addr, ee_addr, ee_wdata};
         repeat (dly) @(posedge sys_clk);
         ee_done  <= 1'b1;
         ee_rdata <= ee_val;
         @(posedge sys_clk);
         ee_done  <= 1'b0;
         ee_rdata <= ~ee_val;
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   function automatic logic [31:0] merge(logic [31:0] w, logic [31:0] r, logic [3:0] be);
      for (int i = 0; i < 4; i++)
         if (be[i]) w[8*i +: 8] = r[8*i +: 8];
      return w;
   endfunction

   //------------------------------------------------------------------
   // One command: write frame, probe refusal, read the answer back
   //------------------------------------------------------------------
   task automatic xfer(input logic [7:0] code, input int n, input logic [7:0] f [7],
                       input logic [7:0] e [7]);
      logic [7:0] b;
      int         m, r0;
      logic       blk;
      m   = 0;
      r0  = n_req;
      blk = (code[6:5] == 2'h2);
      u_host.frame[m++] = code;
      if (blk) u_host.frame[m++] = 8'(n);
      for (int i = 0; i < n; i++) u_host.frame[m++] = f[i];
      u_host.send(m);
      u_host.poke(nk);
      check("busy byte nack", nk, 1'b1);
      u_host.rd_start();
      u_host.get(b);
      check("early read nack", u_host.nk0, 1'b1);
      if (blk) begin
         check("count", b, n);
         u_host.get(b);
      end
      for (int i = 0; i < n; i++) begin
         check("answer byte", b, e[i]);
         if (i < n - 1) u_host.get(b);
      end
      check("one launch", n_req - r0, 1);
   endtask
   task automatic reg_op(input logic [7:0] code, input logic [7:0] cmd, input logic [13:0] a,
                         input logic [31:0] d, input logic c);
      logic [7:0]  f [7];
      logic [7:0]  e [7];
      logic [31:0] x;
      clm    = c;
      rd_val = c ? $urandom : d;
      x      = cmd[4] ? merge(d, rd_val, cmd[3:0]) : d;
      f = '{cmd, a[7:0], {2'h0, a[13:8]}, d[7:0], d[15:8], d[23:16], d[31:24]};
      e = '{{~c & ~cmd[4], ~c & cmd[4], 1'b0, cmd[4:0]}, a[7:0], {2'h0, a[13:8]},
            x[7:0], x[15:8], x[23:16], x[31:24]};
      xfer(code, 7, f, e);
      check("csr request", cap_csr[50:32], {~cmd[4], a, cmd[3:0]});
      if (!cmd[4]) check("csr wdata", cap_csr[31:0], d);
   endtask
   task automatic ee_op(input logic [7:0] cmd, input logic [7:0] dv, input logic [15:0] a,
                        input logic [7:0] d, input logic [2:0] fl);
      logic [7:0] f [7];
      logic [7:0] e [7];
      ee_val = 8'($urandom);
      @(posedge sys_clk);
      flg      <= fl;
      cfg_addr <= 7'($urandom);
      @(posedge sys_clk);
      flg      <= 3'h0;
      f = '{cmd, dv, a[7:0], a[15:8], d, 8'h00, 8'h00};
      e = '{{2'h0, fl, 1'b0, cmd[1:0]}, dv, a[7:0], a[15:8], cmd[0] ? ee_val : d, 8'h0, 8'h0};
      xfer(8'h47, 5, f, e);
      check("ee request", cap_ee[31:8], {~cmd[0], cmd[1] ? dv[7:1] : cfg_addr, a});
      if (!cmd[0]) check("ee wdata", cap_ee[7:0], d);
   endtask

   initial begin
      #200us;
      n_errors++;
      stop_test();
   end
   initial begin
      void'($urandom(10148));
      repeat (10) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (20) @(posedge lnk_clk);
      reg_op(8'h43, 8'h0f, 14'h3abc, 32'h89abcdef, 1'b0);
      reg_op(8'h43, 8'h1f, 14'h0001, 32'h01234567, 1'b0);
      reg_op(8'h43, 8'h15, 14'h3fff, 32'h5a5a5a5a, 1'b1);
      reg_op(8'h43, 8'h00, 14'h0000, 32'hffffffff, 1'b1);
      reg_op(8'h03, 8'h1a, 14'h2001, 32'h00c0ffee, 1'b1);
      ee_op(8'h03, 8'ha4, 16'hbeef, 8'h5c, 3'h7);
      ee_op(8'h00, 8'h02, 16'h0100, 8'ha5, 3'h0);
      ee_op(8'h01, 8'hfe, 16'hffff, 8'h00, 3'h2);
      foreach (bad[i]) begin
         k = n_req;
         u_host.frame = '{bad[i], 8'h07, 8'h1f, 8'h00, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44};
         u_host.send(9);
         u_host.poke(nk);
         check("idle byte taken", nk, 1'b0);
         repeat (60) @(posedge sys_clk);
         check("ignored command", n_req - k, 0);
      end
      for (int t = 0; t < 24; t++) begin
         dly = 1 + $urandom % 6;
         if ($urandom % 2)
            reg_op(8'h43, {3'h0, 5'($urandom)}, 14'($urandom), $urandom, 1'($urandom));
         else
            ee_op({6'h0, 2'($urandom)}, {7'($urandom), 1'b0}, 16'($urandom),
                  8'($urandom), 3'($urandom));
      end
      stop_test();
   end
endmodule // smcd_cmd_tb
